// ### logic/mccc_core.sv
// meter command control core: serial command port, register file, init and power states
module mccc_core #(
    parameter int INIT_CYCLES = 64,
    parameter int OWR_DIV     = 5000
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_n,
    input  wire logic                   sclk,
    input  wire logic                   cs_n,
    input  wire logic                   sdi,
    output logic                        sdo,
    output logic                        sdo_oe,
    input  wire mccc_pkg::mccc_meas_type meas,
    input  wire logic                   freq_valid,
    input  wire logic [23:0]            freq_ratio,
    output logic                        energy_chan,
    output logic [23:0]                 energy_volt,
    output logic [23:0]                 ch1_energy_src,
    output logic [23:0]                 ch2_energy_src,
    output logic                        conv_run,
    output logic                        conv_continuous,
    output logic [5:0]                  cal_code,
    output logic                        analog_on,
    output logic                        osc_on,
    output logic                        data_ready_flag
);
    // init and output word rate counters are sixteen bits wide, so larger settings cannot be served
    if (INIT_CYCLES < 1 || INIT_CYCLES > 65536 ||
        OWR_DIV < 2 || OWR_DIV > 65536) begin : g_bad_param
        $error("mccc_core: bad parameters");
    end

    // ---------------- link domain (sclk) ----------------
    typedef struct packed {
        logic [7:0]  shin;
        logic [2:0]  bitcnt;
        logic [1:0]  wr_left;
        logic [7:0]  wr_cmd;
        logic [23:0] wr_data;
        logic        cmd_tgl;
        mccc_pkg::mccc_cmd_type cmd;
        logic        rd_tgl;
        logic [4:0]  rd_addr;
    } mccc_link_type;
    mccc_link_type lk_ff, nxt_lk;
    logic [31:0]   sh_out_ff;
    logic [1:0]    rd_ack_sync_ff;
    logic          rd_ack_seen_ff;
    logic [23:0]   rd_word;
    logic          rd_ack_tgl_ff;
    logic [7:0]    full_byte;
    logic          cs_async_rst;
    logic          frame_open_ff;
    logic [2:0]    cur_bitcnt;
    logic [1:0]    cur_wr_left;

    assign full_byte    = {lk_ff.shin[6:0], sdi};
    // chip select or reset drops the port back to a byte boundary
    // select realigns port
    assign cs_async_rst = rst_n & ~cs_n;
    // a fresh frame starts at bit zero with no write pending
    assign cur_bitcnt   = frame_open_ff ? lk_ff.bitcnt : 3'h0;
    assign cur_wr_left  = frame_open_ff ? lk_ff.wr_left : 2'h0;

    // byte assembly and command decode, rising edge sampling
    always_comb begin
        nxt_lk        = lk_ff;
        nxt_lk.shin   = full_byte;
        nxt_lk.wr_left = cur_wr_left;
        nxt_lk.bitcnt = cur_bitcnt + 3'h1;
        if (cur_bitcnt == 3'h7) begin
            if (cur_wr_left != 2'h0) begin
                nxt_lk.wr_data = {lk_ff.wr_data[15:0], full_byte};
                nxt_lk.wr_left = cur_wr_left - 2'h1;
                if (cur_wr_left == 2'h1) begin
                    nxt_lk.cmd     = '{1'b1, lk_ff.wr_cmd[5:1], lk_ff.wr_cmd,
                                       {lk_ff.wr_data[15:0], full_byte}};
                    nxt_lk.cmd_tgl = ~lk_ff.cmd_tgl;
                end
            end else if (full_byte == mccc_pkg::CMD_SYNC_ONES ||
                         full_byte == mccc_pkg::CMD_SYNC_ZERO) begin
                nxt_lk.cmd = lk_ff.cmd;
            end else if (full_byte[7] == 1'b0) begin
                if (full_byte[mccc_pkg::CMD_WR_BIT]) begin
                    nxt_lk.wr_cmd  = full_byte;
                    nxt_lk.wr_left = 2'h3;
                end else begin
                    nxt_lk.rd_addr = full_byte[5:1];
                    nxt_lk.rd_tgl  = ~lk_ff.rd_tgl;
                end
            end else begin
                nxt_lk.cmd     = '{1'b0, 5'h00, full_byte, mccc_pkg::DEF_ZERO};
                nxt_lk.cmd_tgl = ~lk_ff.cmd_tgl;
            end
        end
    end

    // realignment while select tied low relies on sync byte stream
    // handshake toggles must survive deselection, or a frame end fakes an event
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            lk_ff <= '0;
        end else begin
            lk_ff <= nxt_lk;
        end
    end

    always_ff @(posedge sclk or negedge cs_async_rst) begin
        if (!cs_async_rst) begin
            frame_open_ff <= 1'b0;
        end else begin
            frame_open_ff <= 1'b1;
        end
    end

    // read data returns from system domain by toggle handshake
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            rd_ack_sync_ff <= 2'h0;
            rd_ack_seen_ff <= 1'b0;
            sh_out_ff      <= '0;
        end else begin
            rd_ack_sync_ff <= {rd_ack_sync_ff[0], rd_ack_tgl_ff};
            if (rd_ack_sync_ff[1] != rd_ack_seen_ff) begin
                rd_ack_seen_ff <= rd_ack_sync_ff[1];
                sh_out_ff      <= {rd_word, 8'h00};
            end else begin
                sh_out_ff <= {sh_out_ff[30:0], 1'b0};
            end
        end
    end

    // host clocks bytes so the word can drain
    assign sdo    = sh_out_ff[31];
    assign sdo_oe = ~cs_n;

    // ---------------- system domain ----------------
    typedef struct packed {
        mccc_pkg::mccc_state_type st;
        logic [2:0]  cmd_sync;
        logic [2:0]  rd_sync;
        logic        rd_tgl_ack;
        logic [23:0] rd_data;
        logic [15:0] init_cnt;
        logic [15:0] owr_cnt;
        logic [11:0] temp_cnt;
        logic [23:0] modes;
        logic [23:0] status;
        logic [23:0] epsilon;
        logic [23:0] temperature_gain;
        logic [23:0] temperature_offset;
        logic [23:0] vfrms;
        logic [23:0] minlvl;
        logic [23:0] margin;
        logic [23:0] temp;
        logic        conv;
        logic        cont;
        logic [5:0]  cal;
    } mccc_sys_type;
    mccc_sys_type s_ff, nxt_s;
    mccc_pkg::mccc_cmd_type cmd_cap;
    logic        cmd_evt;
    logic        rd_evt;
    logic        owr_tick;
    logic [47:0] temp_prod;
    logic [23:0] mag_hi;
    logic [23:0] mag_lo;
    logic        big_is_two;
    logic [23:0] diff;

    // command word is stable before its toggle crosses
    assign cmd_cap   = lk_ff.cmd;
    assign cmd_evt   = s_ff.cmd_sync[2] ^ s_ff.cmd_sync[1];
    assign rd_evt    = s_ff.rd_sync[2] ^ s_ff.rd_sync[1];
    assign owr_tick  = (s_ff.owr_cnt == 16'(OWR_DIV - 1));
    assign temp_prod = 48'($signed(meas.temp_raw) * $signed(s_ff.temperature_gain));
    assign big_is_two = meas.ch2_rms > meas.ch1_rms;
    assign mag_hi    = big_is_two ? meas.ch2_rms : meas.ch1_rms;
    assign mag_lo    = big_is_two ? meas.ch1_rms : meas.ch2_rms;
    assign diff      = mag_hi - mag_lo;

    always_comb begin
        nxt_s          = s_ff;
        nxt_s.cmd_sync = {s_ff.cmd_sync[1:0], lk_ff.cmd_tgl};
        nxt_s.rd_sync  = {s_ff.rd_sync[1:0], lk_ff.rd_tgl};
        nxt_s.owr_cnt  = owr_tick ? 16'h0000 : s_ff.owr_cnt + 16'h0001;
        // register read, allowed in every state
        // reads during init
        if (rd_evt) begin
            case (lk_ff.rd_addr)
                mccc_pkg::ADDR_MODES:   nxt_s.rd_data = s_ff.modes;
                mccc_pkg::ADDR_STATUS:  nxt_s.rd_data = s_ff.status;
                mccc_pkg::ADDR_TEMP:    nxt_s.rd_data = s_ff.temp;
                mccc_pkg::ADDR_EPSILON: nxt_s.rd_data = s_ff.epsilon;
                mccc_pkg::ADDR_TEMPERATURE_GAIN:   nxt_s.rd_data = s_ff.temperature_gain;
                mccc_pkg::ADDR_TEMPERATURE_OFFSET:    nxt_s.rd_data = s_ff.temperature_offset;
                mccc_pkg::ADDR_VFRMS:   nxt_s.rd_data = s_ff.vfrms;
                mccc_pkg::ADDR_MINLVL:  nxt_s.rd_data = s_ff.minlvl;
                mccc_pkg::ADDR_MARGIN:  nxt_s.rd_data = s_ff.margin;
                default:                nxt_s.rd_data = mccc_pkg::DEF_ZERO;
            endcase
            nxt_s.rd_tgl_ack = ~s_ff.rd_tgl_ack;
        end
        case (s_ff.st)
            mccc_pkg::MCCC_ST_INIT: begin
                nxt_s.epsilon  = mccc_pkg::DEF_EPSILON;
                nxt_s.temperature_gain    = mccc_pkg::DEF_TEMPERATURE_GAIN;
                nxt_s.temperature_offset     = mccc_pkg::DEF_TEMPERATURE_OFFSET;
                nxt_s.vfrms    = mccc_pkg::DEF_VFRMS;
                nxt_s.modes    = mccc_pkg::DEF_ZERO;
                nxt_s.minlvl   = mccc_pkg::DEF_ZERO;
                nxt_s.margin   = mccc_pkg::DEF_ZERO;
                nxt_s.temp     = mccc_pkg::DEF_ZERO;
                nxt_s.status   = mccc_pkg::DEF_ZERO;
                nxt_s.conv     = 1'b0;
                nxt_s.cal      = 6'h00;
                nxt_s.temp_cnt = 12'h000;
                nxt_s.init_cnt = s_ff.init_cnt + 16'h0001;
                if (s_ff.init_cnt == 16'(INIT_CYCLES - 1)) begin
                    nxt_s.status[mccc_pkg::STAT_DATA_READY_FLAG] = 1'b1;
                    nxt_s.st = mccc_pkg::MCCC_ST_ACTIVE;
                end
            end
            mccc_pkg::MCCC_ST_ACTIVE, mccc_pkg::MCCC_ST_RUN: begin
                if (s_ff.modes[mccc_pkg::MODE_AFC] && freq_valid) begin
                    nxt_s.epsilon = freq_ratio;
                    nxt_s.status[mccc_pkg::STAT_FUP] = 1'b1;
                end
                if (owr_tick) begin
                    if (s_ff.temp_cnt == 12'(mccc_pkg::TEMP_PERIOD_SAMPLES - 1)) begin
                        nxt_s.temp_cnt = 12'h000;
                        nxt_s.temp = temp_prod[mccc_pkg::TEMPERATURE_GAIN_POINT +: 24] + s_ff.temperature_offset;
                        nxt_s.status[mccc_pkg::STAT_TUP] = 1'b1;
                    end else begin
                        nxt_s.temp_cnt = s_ff.temp_cnt + 12'h001;
                    end
                    if (!s_ff.modes[mccc_pkg::MODE_HOLD] && mag_hi > s_ff.minlvl &&
                        diff > s_ff.margin) begin
                        nxt_s.modes[mccc_pkg::MODE_CHAN] = big_is_two;
                    end
                end
            end
            mccc_pkg::MCCC_ST_STANDBY, mccc_pkg::MCCC_ST_SLEEP: begin
                nxt_s.conv = 1'b0;
            end
            default: begin
                nxt_s.st = mccc_pkg::MCCC_ST_INIT;
            end
        endcase
        // host commands; a host write of a flag bit loses to a same-cycle set
        if (cmd_evt) begin
            if (cmd_cap.is_write && s_ff.st != mccc_pkg::MCCC_ST_SLEEP) begin
                case (cmd_cap.addr)
                    mccc_pkg::ADDR_MODES:   nxt_s.modes   = cmd_cap.data;
                    mccc_pkg::ADDR_STATUS:  nxt_s.status  = nxt_s.status & ~cmd_cap.data
                                                          | (nxt_s.status & ~s_ff.status);
                    mccc_pkg::ADDR_EPSILON: nxt_s.epsilon = cmd_cap.data;
                    mccc_pkg::ADDR_TEMPERATURE_GAIN:   nxt_s.temperature_gain   = cmd_cap.data;
                    mccc_pkg::ADDR_TEMPERATURE_OFFSET:    nxt_s.temperature_offset    = cmd_cap.data;
                    mccc_pkg::ADDR_VFRMS:   nxt_s.vfrms   = cmd_cap.data;
                    mccc_pkg::ADDR_MINLVL:  nxt_s.minlvl  = cmd_cap.data;
                    mccc_pkg::ADDR_MARGIN:  nxt_s.margin  = cmd_cap.data;
                    default:                nxt_s.temp    = nxt_s.temp;
                endcase
            end else if (!cmd_cap.is_write) begin
                nxt_s.conv = 1'b0;
                nxt_s.cal  = 6'h00;
                if ((cmd_cap.cmd & mccc_pkg::CMD_PWR_MASK) == mccc_pkg::CMD_PWR_CODE) begin
                    case (cmd_cap.cmd[5:4])
                        mccc_pkg::PWR_SOFT_RESET: begin
                            nxt_s.st       = mccc_pkg::MCCC_ST_INIT;
                            nxt_s.init_cnt = 16'h0000;
                            nxt_s.status   = mccc_pkg::DEF_ZERO;
                        end
                        mccc_pkg::PWR_SLEEP:   nxt_s.st = mccc_pkg::MCCC_ST_SLEEP;
                        mccc_pkg::PWR_STANDBY: nxt_s.st = mccc_pkg::MCCC_ST_STANDBY;
                        default: begin
                            if (s_ff.st == mccc_pkg::MCCC_ST_SLEEP) begin
                                nxt_s.st       = mccc_pkg::MCCC_ST_INIT;
                                nxt_s.init_cnt = 16'h0000;
                                nxt_s.status   = mccc_pkg::DEF_ZERO;
                            end else begin
                                nxt_s.st = mccc_pkg::MCCC_ST_ACTIVE;
                            end
                        end
                    endcase
                end else if (s_ff.st == mccc_pkg::MCCC_ST_SLEEP) begin
                    nxt_s.st = mccc_pkg::MCCC_ST_SLEEP;
                end else if ((cmd_cap.cmd & mccc_pkg::CMD_CONV_MASK) ==
                             mccc_pkg::CMD_CONV_CODE) begin
                    nxt_s.st   = mccc_pkg::MCCC_ST_RUN;
                    nxt_s.conv = 1'b1;
                    nxt_s.cont = cmd_cap.cmd[mccc_pkg::CMD_CONT_BIT];
                end else if (cmd_cap.cmd[7:6] == mccc_pkg::CMD_CAL_TOP &&
                             cmd_cap.cmd[5:0] != 6'h00) begin
                    nxt_s.st  = mccc_pkg::MCCC_ST_RUN;
                    nxt_s.cal = cmd_cap.cmd[5:0];
                end else begin
                    nxt_s.st = mccc_pkg::MCCC_ST_ACTIVE;
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_ff    <= '0;
            s_ff.st <= mccc_pkg::MCCC_ST_INIT;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign rd_word       = s_ff.rd_data;
    assign rd_ack_tgl_ff = s_ff.rd_tgl_ack;

    assign ch1_energy_src  = meas.ch1_rms;
    assign ch2_energy_src  = meas.ch2_rms;
    assign energy_chan     = s_ff.modes[mccc_pkg::MODE_CHAN];
    assign energy_volt     = s_ff.modes[mccc_pkg::MODE_FIXED_VOLTAGE_ENABLE] ? s_ff.vfrms : meas.volt_rms;
    assign conv_run        = s_ff.conv;
    assign conv_continuous = s_ff.cont;
    assign cal_code        = s_ff.cal;
    assign analog_on       = s_ff.st != mccc_pkg::MCCC_ST_STANDBY &&
                             s_ff.st != mccc_pkg::MCCC_ST_SLEEP;
    assign osc_on          = s_ff.st != mccc_pkg::MCCC_ST_SLEEP;
    assign data_ready_flag = s_ff.status[mccc_pkg::STAT_DATA_READY_FLAG];
endmodule : mccc_core

// ### include/mccc_pkg.sv
// package for the meter command control core: constants, codes and state types
package mccc_pkg;
    // command byte fields and encodings
    localparam logic [7:0] CMD_SYNC_ZERO  = 8'hFE;
    localparam logic [7:0] CMD_SYNC_ONES  = 8'hFF;
    localparam logic [7:0] CMD_CONV_MASK  = 8'hF7;
    localparam logic [7:0] CMD_CONV_CODE  = 8'hE0;
    localparam logic [7:0] CMD_PWR_MASK   = 8'hCF;
    localparam logic [7:0] CMD_PWR_CODE   = 8'h80;
    localparam logic [1:0] CMD_CAL_TOP    = 2'h2;
    localparam int         CMD_WR_BIT     = 6;
    localparam int         CMD_CONT_BIT   = 3;
    localparam logic [1:0] PWR_SOFT_RESET = 2'h0;
    localparam logic [1:0] PWR_SLEEP      = 2'h1;
    localparam logic [1:0] PWR_WAKE       = 2'h2;
    localparam logic [1:0] PWR_STANDBY    = 2'h3;

    // register map of the local register file (page 0 addresses)
    localparam logic [4:0] ADDR_MODES     = 5'h00;
    localparam logic [4:0] ADDR_STATUS    = 5'h0F;
    localparam logic [4:0] ADDR_TEMP      = 5'h1B;
    localparam logic [4:0] ADDR_EPSILON   = 5'h12;
    localparam logic [4:0] ADDR_TEMPERATURE_GAIN     = 5'h13;
    localparam logic [4:0] ADDR_TEMPERATURE_OFFSET      = 5'h14;
    localparam logic [4:0] ADDR_VFRMS     = 5'h15;
    localparam logic [4:0] ADDR_MINLVL    = 5'h16;
    localparam logic [4:0] ADDR_MARGIN    = 5'h17;
    localparam int         REG_COUNT      = 32;

    // default values loaded by the initialization program
    localparam logic [23:0] DEF_EPSILON   = 24'h019999; // 0.0125, sign at bit 23
    localparam logic [23:0] DEF_TEMPERATURE_GAIN     = 24'h2F03C3; // binary point at bit 17
    localparam logic [23:0] DEF_TEMPERATURE_OFFSET      = 24'hF3D35A; // binary point at bit 23
    localparam logic [23:0] DEF_VFRMS     = 24'h5A8279; // 0.707107 full-scale rms
    localparam logic [23:0] DEF_ZERO      = 24'h000000;
    localparam int          TEMPERATURE_GAIN_POINT   = 17;
    localparam int          TEMPERATURE_OFFSET_POINT    = 23;

    // modes register bit positions
    localparam int MODE_AFC   = 0;
    localparam int MODE_FIXED_VOLTAGE_ENABLE  = 1;
    localparam int MODE_HOLD  = 2;
    localparam int MODE_CHAN  = 3;
    // status register bit positions
    localparam int STAT_DATA_READY_FLAG  = 23;
    localparam int STAT_FUP   = 5;
    localparam int STAT_TUP   = 7;

    // temperature refresh period in output word rate samples
    localparam int TEMP_PERIOD_SAMPLES = 2240;

    // power and program states, one-hot
    typedef enum logic [4:0] {
        MCCC_ST_INIT    = 5'h01,
        MCCC_ST_ACTIVE  = 5'h02,
        MCCC_ST_STANDBY = 5'h04,
        MCCC_ST_SLEEP   = 5'h08,
        MCCC_ST_RUN     = 5'h10
    } mccc_state_type;

    // command passed from the link domain to the system domain
    typedef struct packed {
        logic        is_write;
        logic [4:0]  addr;
        logic [7:0]  cmd;
        logic [23:0] data;
    } mccc_cmd_type;

    // measurement inputs for the energy channel selector, the energy voltage and the temperature reading
    typedef struct packed {
        logic [23:0] ch1_rms;
        logic [23:0] ch2_rms;
        logic [23:0] volt_rms;
        logic [23:0] temp_raw;
    } mccc_meas_type;
endpackage : mccc_pkg

// ### verif/mccc_host_model.sv
// host model: drives the four-wire serial port, shifts bytes msb first
module mccc_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      sdi,
    input  wire logic sdo
);
    timeunit 1ns;
    timeprecision 1ns;
    // link clock stands still low between frames
    initial begin
        sclk = 1'b0;
        cs_n = 1'b0; // selected until the first frame so reset reaches the port
        sdi  = 1'b0;
    end
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sdi = tx[i];
            #40 sclk = 1'b1;
            rx[i] = sdo;
            #40 sclk = 0;
        end
    endtask : xfer
    task automatic frame(input logic [7:0] c, input int n, input logic [23:0] d,
                         output logic [31:0] cap);
        logic [7:0] rx;
        cs_n = 1'b0;
        #40 xfer(c, rx);
        #400;
        for (int b = 0; b < n; b++) begin
            xfer((c[7:6] == 2'h1) ? d[23-8*b -: 8] : 8'hFF, rx);
            cap = {cap[23:0], rx};
        end
        #40 cs_n = 1'b1;
        // released line shows no stale value
        sdi = ~sdi;
        // one idle link period, so select never pulses within a time step
        #80;
    endtask : frame
endmodule : mccc_host_model

// ### verif/mccc_core_sva.sv
// port assertions for the meter command control core
module mccc_core_sva #(
    parameter int INIT_CYCLES = 64
) (
    input wire logic                    clk_sys,
    input wire logic                    rst_n,
    input wire logic                    cs_n,
    input wire logic                    sdo_oe,
    input wire mccc_pkg::mccc_meas_type meas,
    input wire logic [23:0]             energy_volt,
    input wire logic [23:0]             ch1_energy_src,
    input wire logic [23:0]             ch2_energy_src,
    input wire logic                    conv_run,
    input wire logic [5:0]              cal_code,
    input wire logic                    analog_on,
    input wire logic                    osc_on,
    input wire logic                    data_ready_flag
);
    logic [15:0] cnt_ff;
    logic [15:0] nxt_cnt;
    // cycles since reset release, saturates so it never wraps
    always_comb nxt_cnt = (cnt_ff == 16'hFFFF) ? cnt_ff : cnt_ff + 16'h0001;
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            cnt_ff <= 16'h0000;
        else
            cnt_ff <= nxt_cnt;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_oe; sdo_oe == !cs_n; endproperty
    a_oe: assert property (p_oe) else $error("sdo enable not tracking select");
    property p_ch1; $stable(meas.ch1_rms) [*2] |-> ch1_energy_src == meas.ch1_rms; endproperty
    a_ch1: assert property (p_ch1) else $error("channel one source wrong");
    property p_ch2; $stable(meas.ch2_rms) [*2] |-> ch2_energy_src == meas.ch2_rms; endproperty
    a_ch2: assert property (p_ch2) else $error("channel two source wrong");
    property p_rdy_init; $rose(rst_n) |-> !data_ready_flag && !conv_run && cal_code == 6'h00;
    endproperty
    a_rdy_init: assert property (p_rdy_init) else $error("state not cleared by reset");
    property p_rdy_early; $rose(data_ready_flag) |-> cnt_ff >= INIT_CYCLES - 2; endproperty
    a_rdy_early: assert property (p_rdy_early) else $error("ready before init done");
    property p_rdy_late; cnt_ff == INIT_CYCLES + 8 |-> data_ready_flag; endproperty
    a_rdy_late: assert property (p_rdy_late) else $error("ready missing after init");
    property p_pwr; analog_on |-> osc_on; endproperty
    a_pwr: assert property (p_pwr) else $error("analog on with oscillator off");
    property p_volt; $rose(data_ready_flag) |-> energy_volt == meas.volt_rms; endproperty
    a_volt: assert property (p_volt) else $error("fixed voltage after init");
endmodule : mccc_core_sva

// ### verif/meter_command_control_core_tb.sv
// self-checking testbench for the meter command control core
module meter_command_control_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                    clk_sys = 1'b0;
    logic                    rst_n = 1'b1;
    logic                    sclk, cs_n, sdi, sdo, sdo_oe, freq_valid = 1'b0;
    logic [23:0]             freq_ratio = 24'h000000;
    mccc_pkg::mccc_meas_type meas = {24'h123456, 24'h234567, 24'h345678, 24'h456789};
    logic                    energy_chan, conv_run, conv_continuous, analog_on, osc_on, rdy;
    logic [23:0]             energy_volt, ch1_src, ch2_src;
    logic [5:0]              cal_code;
    logic [31:0]             cap;
    int                      bad_count = 0;
    int                      num_checks = 0;
    always #25 clk_sys = ~clk_sys;
    mccc_host_model i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
    mccc_core #(.INIT_CYCLES(64), .OWR_DIV(4)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .meas(meas),
        .freq_valid(freq_valid), .freq_ratio(freq_ratio), .energy_chan(energy_chan),
        .energy_volt(energy_volt), .ch1_energy_src(ch1_src), .ch2_energy_src(ch2_src),
        .conv_run(conv_run), .conv_continuous(conv_continuous), .cal_code(cal_code),
        .analog_on(analog_on), .osc_on(osc_on), .data_ready_flag(rdy));
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : settle
    // word loads on the third link fall of the first fill byte
    task automatic rd(input logic [4:0] a, input logic [23:0] exp, input logic [23:0] m);
        i_host.frame({2'h0, a, 1'b0}, 4, 24'h000000, cap);
        check(cap[28 -: 24] & m, exp & m);
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [23:0] d, input int n);
        i_host.frame({2'h1, a, 1'b0}, n, d, cap);
        settle(10);
    endtask : wr
    task automatic cmd(input logic [7:0] c);
        i_host.frame(c, 0, 24'h000000, cap);
        settle(10);
    endtask : cmd
    task automatic wait_rdy();
        for (int t = 0; t < 500 && rdy !== 1'b1; t++) @(negedge clk_sys);
        check(rdy, 1'b1);
    endtask : wait_rdy
    task automatic t_init();
        check(rdy, 1'b0);
        wait_rdy();
        rd(mccc_pkg::ADDR_EPSILON, 24'h019999, 24'hFFFFFF);
        rd(mccc_pkg::ADDR_TEMPERATURE_GAIN, 24'h2F03C3, 24'hFFFFFF);
        rd(mccc_pkg::ADDR_TEMPERATURE_OFFSET, 24'hF3D35A, 24'hFFFFFF);
        rd(mccc_pkg::ADDR_VFRMS, mccc_pkg::DEF_VFRMS, 24'hFFFFFF);
    endtask : t_init
    // full write lands, short one does not
    task automatic t_write();
        wr(mccc_pkg::ADDR_MARGIN, 24'hA5C33C, 3);
        wr(mccc_pkg::ADDR_MARGIN, 24'h5A5A5A, 2);
        rd(mccc_pkg::ADDR_MARGIN, 24'hA5C33C, 24'hFFFFFF);
    endtask : t_write
    // zero margin: free selection would move to the larger channel two
    task automatic t_modes();
        wr(mccc_pkg::ADDR_MARGIN, 24'h000000, 3);
        wr(mccc_pkg::ADDR_MODES, 24'h000006, 3);
        check(energy_chan, 1'b0);
        check(energy_volt, mccc_pkg::DEF_VFRMS);
        wr(mccc_pkg::ADDR_MODES, 24'h000000, 3);
        check(energy_volt, meas.volt_rms);
        check(energy_chan, 1'b1);
        wr(mccc_pkg::ADDR_MARGIN, 24'hA5C33C, 3);
    endtask : t_modes
    task automatic t_flags();
        wr(mccc_pkg::ADDR_MODES, 24'h000001, 3);
        freq_ratio = 24'h01EB85;
        freq_valid = 1'b1;
        settle(1);
        freq_valid = 1'b0;
        settle(5);
        rd(mccc_pkg::ADDR_EPSILON, 24'h01EB85, 24'hFFFFFF);
        rd(mccc_pkg::ADDR_STATUS, 24'h800020, 24'h800020);
        settle(9000);
        rd(mccc_pkg::ADDR_STATUS, 24'h000080, 24'h000080);
    endtask : t_flags
    task automatic t_instr();
        cmd(8'hE8);
        check({conv_run, conv_continuous}, 2'h3);
        cmd(8'hE0);
        check(conv_continuous, 1'b0);
        cmd(8'h91);
        check({conv_run, cal_code}, 7'h11);
        cmd(8'hB0);
        check({analog_on, osc_on}, 2'h1);
        cmd(8'hA0);
        check(analog_on, 1'b1);
        rd(mccc_pkg::ADDR_MARGIN, 24'hA5C33C, 24'hFFFFFF);
        cmd(8'h90);
        check(osc_on, 1'b0);
        cmd(8'hA0);
        wait_rdy();
        rd(mccc_pkg::ADDR_MARGIN, 24'h000000, 24'hFFFFFF);
        wr(mccc_pkg::ADDR_MARGIN, 24'h00F00F, 3);
        cmd(8'h80);
        check(rdy, 1'b0);
        rd(mccc_pkg::ADDR_STATUS, 24'h000000, 24'h800000);
        wait_rdy();
        rd(mccc_pkg::ADDR_MARGIN, 24'h000000, 24'hFFFFFF);
    endtask : t_instr
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : complete_run
    // main sequence, inputs change on the falling clock edge
    initial begin
        #1 rst_n = 1'b0;
        settle(2);
        rst_n = 1'b1;
        t_init();
        t_write();
        t_modes();
        t_flags();
        t_instr();
        complete_run();
    end
    // hang guard, well past the expected run length
    initial begin
        #3000000;
        bad_count++;
        complete_run();
    end
endmodule : meter_command_control_core_tb
bind mccc_core mccc_core_sva #(.INIT_CYCLES(INIT_CYCLES)) i_sva (.clk_sys(clk_sys),
    .rst_n(rst_n), .cs_n(cs_n), .sdo_oe(sdo_oe), .meas(meas), .energy_volt(energy_volt),
    .ch1_energy_src(ch1_energy_src), .ch2_energy_src(ch2_energy_src), .conv_run(conv_run),
    .cal_code(cal_code), .analog_on(analog_on), .osc_on(osc_on),
    .data_ready_flag(data_ready_flag));
